// ==== src/cpusrb_core.sv ====
// Implementation choices: the address map and the AXI4-Lite slave port.
`include "cpusrb_defines.svh"

// What this block does
// RL1: Hold 16-bit program counter for fetch.
// RL2: 16-bit accumulator; 8-bit ops use low byte.
// RL3: 16-bit temporary operand; low byte for bytes.
// RL4: 16-bit index register and extra pointer.
// RL5: 16-bit stack pointer marks stack location.
// RL6: Status word: bank pointer high, flags low.
// RL7: Half carry on carry/borrow bit3 to 4.
// RL8: Interrupt enable gates requests; reset clears.
// RL9: Serve only levels above mask; 3 masks none. Code takes levels numerically below the mask, so 3 still blocks level 3.
// RL10: Negative flag copies result MSB.
// RL11: Zero flag set on zero result.
// RL12: Overflow flag on two's-complement overflow.
// RL13: Carry from bit 7, or shifted-out bit.
// RL14: Up to 32 banks of eight 8-bit registers.
// RL15: Usable banks limited by fitted RAM.
// RL16: 64K map: I/O low, data, program high.
// RL17: Programming mode maps upper half to 0000.
// RL18: Fixed bank pointer to RAM address mapping.
module cpusrb_core
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  irq_req_level,
  input  wire logic        irq_req_valid,
  output logic             irq_take,
  output logic [15:0]      bank_base_addr,
  output logic [15:0]      fetch_phys_addr
);

  typedef struct packed
  {
    logic [15:0] pc;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] ix;
    logic [15:0] ep;
    logic [15:0] sp;
    logic [7:0]  bank;
    logic [7:0]  cc;
    logic [5:0]  nbanks;
    logic        prog_mode;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq_take;
    logic [15:0] bank_addr;
    logic [15:0] fetch_addr;
  } cpusrb_state_t;

  cpusrb_state_t st_r;
  cpusrb_state_t st_nxt;
  cpusrb_pkg::cpusrb_alu_out_t alu_out;
  logic [2:0]    alu_op;
  logic          alu_wide;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  be);
    logic [15:0] r;
    r = old;
    if (be[0])
      r[7:0] = d[7:0];
    if (be[1])
      r[15:8] = d[15:8];
    return r;
  endfunction

  // Banks occupy eight bytes each above the I/O area. [RL18] [RL14]
  function automatic logic [15:0] bank_addr_of(input logic [7:0] b);
    return `CPUSRB_BANK_BASE + {8'h00, b[4:0], 3'b000};
  endfunction

  // Pointer writes keep their low five bits, then are clamped to the fitted banks. [RL15]
  function automatic logic [7:0] clamp_bank(input logic [7:0] b,
                                            input logic [5:0] n);
    logic [7:0] r;
    r = {3'b000, b[4:0]};
    if ({2'b00, r} >= {2'b00, n})
      r = {2'b00, n} - 8'h01;
    return r;
  endfunction

  // Taken from the held or the incoming word, so no loop through st_nxt.
  assign alu_op   = st_r.w_got ? st_r.wdata[`CPUSRB_OP_LSB +: 3]
                               : s_axi_wdata[`CPUSRB_OP_LSB +: 3];
  assign alu_wide = st_r.w_got ? st_r.wdata[`CPUSRB_OP_LSB + 3]
                               : s_axi_wdata[`CPUSRB_OP_LSB + 3];

  cpusrb_alu u_alu
  (
    .op   (alu_op),
    .wide (alu_wide),
    .a    (st_r.acc),
    .t    (st_r.tmp),
    .cin  (st_r.cc[`CPUSRB_CC_C]),
    .out  (alu_out)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic        do_wr;
    logic [7:0]  a;
    logic [15:0] w16;
    logic [7:0]  cc;
    do_wr = 1'b0;
    a     = 8'h00;
    w16   = 16'h0000;
    cc    = 8'h00;
    st_nxt = st_r;

    if (s_axi_awvalid && !st_r.aw_got)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;

    if (st_nxt.aw_got && st_nxt.w_got && !st_r.bvalid)
    begin
      do_wr = 1'b1;
      a     = st_nxt.awaddr;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = `CPUSRB_RESP_OK;
    end

    if (do_wr)
    begin
      if (a == `CPUSRB_OFF_PC)
        st_nxt.pc = merge16(st_r.pc, st_nxt.wdata, st_nxt.wstrb); // [RL1]
      else if (a == `CPUSRB_OFF_ACC)
        st_nxt.acc = merge16(st_r.acc, st_nxt.wdata, st_nxt.wstrb); // [RL2]
      else if (a == `CPUSRB_OFF_TMP)
        st_nxt.tmp = merge16(st_r.tmp, st_nxt.wdata, st_nxt.wstrb); // [RL3]
      else if (a == `CPUSRB_OFF_IX)
        st_nxt.ix = merge16(st_r.ix, st_nxt.wdata, st_nxt.wstrb); // [RL4]
      else if (a == `CPUSRB_OFF_EP)
        st_nxt.ep = merge16(st_r.ep, st_nxt.wdata, st_nxt.wstrb); // [RL4]
      else if (a == `CPUSRB_OFF_SP)
        st_nxt.sp = merge16(st_r.sp, st_nxt.wdata, st_nxt.wstrb); // [RL5]
      else if (a == `CPUSRB_OFF_PSW)
      begin
        // Bank pointer in the high byte, flags in the low. [RL6]
        w16 = merge16({st_r.bank, st_r.cc}, st_nxt.wdata, st_nxt.wstrb);
        st_nxt.cc = w16[7:0];
        if (st_nxt.wstrb[1])
          st_nxt.bank = clamp_bank(w16[15:8], st_r.nbanks); // [RL14]
      end
      else if (a == `CPUSRB_OFF_ALU)
      begin
        // The result lands in the accumulator, flags in the low byte.
        cc = st_r.cc;
        cc[`CPUSRB_CC_H] = alu_out.h; // [RL7]
        cc[`CPUSRB_CC_N] = alu_out.n; // [RL10]
        cc[`CPUSRB_CC_Z] = alu_out.z; // [RL11]
        cc[`CPUSRB_CC_V] = alu_out.v; // [RL12]
        cc[`CPUSRB_CC_C] = alu_out.c; // [RL13]
        st_nxt.cc = cc;
        if (alu_wide)
          st_nxt.acc = alu_out.res;
        else
          st_nxt.acc = {st_r.acc[15:8], alu_out.res[7:0]}; // [RL2]
      end
      else if (a == `CPUSRB_OFF_CFG)
      begin
        if (st_nxt.wstrb[0])
        begin
          st_nxt.prog_mode = st_nxt.wdata[0];
        end
        if (st_nxt.wstrb[1])
        begin
          if (st_nxt.wdata[13:8] == 6'h00
              || st_nxt.wdata[13:8] > `CPUSRB_MAX_BANKS)
            st_nxt.nbanks = `CPUSRB_MAX_BANKS;
          else
            st_nxt.nbanks = st_nxt.wdata[13:8]; // [RL15]
          st_nxt.bank = clamp_bank(st_r.bank, st_nxt.nbanks);
        end
      end
      else
        st_nxt.bresp = `CPUSRB_RESP_ERR;
    end

    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = `CPUSRB_RESP_OK;
      a = s_axi_araddr;
      if (a == `CPUSRB_OFF_PC)
        st_nxt.rdata = {16'h0000, st_r.pc};
      else if (a == `CPUSRB_OFF_ACC)
        st_nxt.rdata = {16'h0000, st_r.acc};
      else if (a == `CPUSRB_OFF_TMP)
        st_nxt.rdata = {16'h0000, st_r.tmp};
      else if (a == `CPUSRB_OFF_IX)
        st_nxt.rdata = {16'h0000, st_r.ix};
      else if (a == `CPUSRB_OFF_EP)
        st_nxt.rdata = {16'h0000, st_r.ep};
      else if (a == `CPUSRB_OFF_SP)
        st_nxt.rdata = {16'h0000, st_r.sp};
      else if (a == `CPUSRB_OFF_PSW)
        st_nxt.rdata = {16'h0000, st_r.bank, st_r.cc};
      else if (a == `CPUSRB_OFF_ALU)
        st_nxt.rdata = {24'h000000, st_r.cc};
      else if (a == `CPUSRB_OFF_IRQ)
        st_nxt.rdata = {31'h00000000, st_r.irq_take};
      else if (a == `CPUSRB_OFF_BANK)
        st_nxt.rdata = {16'h0000, st_r.bank_addr};
      else if (a == `CPUSRB_OFF_MAP)
        st_nxt.rdata = {16'h0000, st_r.fetch_addr};
      else if (a == `CPUSRB_OFF_CFG)
        st_nxt.rdata = {18'h00000, st_r.nbanks, 7'h00, st_r.prog_mode};
      else
      begin
        st_nxt.rdata = 32'h00000000;
        st_nxt.rresp = `CPUSRB_RESP_ERR;
      end
    end

    // Enable flag and level mask together; only levels below the mask pass, so 3 still masks level 3.
    st_nxt.irq_take = irq_req_valid && st_r.cc[`CPUSRB_CC_I] // [RL8]
      && (irq_req_level < st_r.cc[`CPUSRB_CC_IL1:`CPUSRB_CC_IL0]); // [RL9]

    st_nxt.bank_addr = bank_addr_of(st_r.bank); // [RL18]

    // Program sits in the top half; programming mode folds it down.
    if (st_r.prog_mode && st_r.pc >= `CPUSRB_PROG_BASE) // [RL16]
      st_nxt.fetch_addr = st_r.pc & `CPUSRB_PROG_MASK; // [RL17]
    else
      st_nxt.fetch_addr = st_r.pc;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r        <= '0;
      // Reset leaves interrupts disabled, mask at level 3. [RL8]
      st_r.cc     <= `CPUSRB_RST_CC;
      st_r.nbanks <= `CPUSRB_RST_BANKS;
      st_r.bank_addr <= `CPUSRB_BANK_BASE;
    end
    else
      st_r <= st_nxt;
  end

  assign s_axi_awready   = !st_r.aw_got;
  assign s_axi_wready    = !st_r.w_got;
  assign s_axi_bvalid    = st_r.bvalid;
  assign s_axi_bresp     = st_r.bresp;
  assign s_axi_arready   = !st_r.rvalid;
  assign s_axi_rvalid    = st_r.rvalid;
  assign s_axi_rdata     = st_r.rdata;
  assign s_axi_rresp     = st_r.rresp;
  assign irq_take        = st_r.irq_take;
  assign bank_base_addr  = st_r.bank_addr;
  assign fetch_phys_addr = st_r.fetch_addr;

endmodule

// ==== src/cpusrb_defines.svh ====
`ifndef CPUSRB_DEFINES_SVH
`define CPUSRB_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets, byte addresses on the AXI4-Lite slave
// ----------------------------------------------------------------
`define CPUSRB_OFF_PC    8'h00
`define CPUSRB_OFF_ACC   8'h04
`define CPUSRB_OFF_TMP   8'h08
`define CPUSRB_OFF_IX    8'h0c
`define CPUSRB_OFF_EP    8'h10
`define CPUSRB_OFF_SP    8'h14
`define CPUSRB_OFF_PSW   8'h18
`define CPUSRB_OFF_ALU   8'h1c
`define CPUSRB_OFF_IRQ   8'h20
`define CPUSRB_OFF_BANK  8'h24
`define CPUSRB_OFF_MAP   8'h28
`define CPUSRB_OFF_CFG   8'h2c

// ----------------------------------------------------------------
// Condition-code bit positions
// ----------------------------------------------------------------
`define CPUSRB_CC_C      0
`define CPUSRB_CC_V      1
`define CPUSRB_CC_Z      2
`define CPUSRB_CC_N      3
`define CPUSRB_CC_IL0    4
`define CPUSRB_CC_IL1    5
`define CPUSRB_CC_I      6
`define CPUSRB_CC_H      7

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define CPUSRB_RST_W16   16'h0000
`define CPUSRB_RST_CC    8'h30
`define CPUSRB_RST_BANKS 6'h20
`define CPUSRB_MAX_BANKS 6'h20
`define CPUSRB_BANK_BASE 16'h0100
`define CPUSRB_PROG_BASE 16'h8000
`define CPUSRB_PROG_MASK 16'h7fff
`define CPUSRB_RESP_OK   2'b00
`define CPUSRB_RESP_ERR  2'b10
`define CPUSRB_OP_LSB    8
`define CPUSRB_SHL_LSB   12

`endif

// ==== src/cpusrb_pkg.sv ====
package cpusrb_pkg;

  typedef enum logic [2:0]
  {
    CPUSRB_OP_ADD = 3'b000,
    CPUSRB_OP_SUB = 3'b001,
    CPUSRB_OP_SHL = 3'b010,
    CPUSRB_OP_SHR = 3'b011,
    CPUSRB_OP_AND = 3'b100,
    CPUSRB_OP_OR  = 3'b101
  } cpusrb_op_t;

  typedef struct packed
  {
    logic        c;
    logic        v;
    logic        z;
    logic        n;
    logic        h;
    logic [15:0] res;
  } cpusrb_alu_out_t;

endpackage

// ==== src/cpusrb_alu.sv ====
`include "cpusrb_defines.svh"

module cpusrb_alu
(
  input  wire logic [2:0]               op,
  input  wire logic                     wide,
  input  wire logic [15:0]              a,
  input  wire logic [15:0]              t,
  input  wire logic                     cin,
  output cpusrb_pkg::cpusrb_alu_out_t   out
);

  logic [16:0] sum;
  logic [4:0]  nib;
  logic [8:0]  lo;
  logic        msb;
  logic        amsb;
  logic        tmsb;

  always_comb
  begin
    out = '0;
    sum = 17'h00000;
    nib = {1'b0, a[3:0]} + {1'b0, t[3:0]};
    lo  = {1'b0, a[7:0]} + {1'b0, t[7:0]};
    case (cpusrb_pkg::cpusrb_op_t'(op))
      cpusrb_pkg::CPUSRB_OP_ADD:
      begin
        sum = {1'b0, a} + {1'b0, t};
      end
      cpusrb_pkg::CPUSRB_OP_SUB:
      begin
        sum = {1'b0, a} - {1'b0, t};
        nib = {1'b0, a[3:0]} - {1'b0, t[3:0]};
        lo  = {1'b0, a[7:0]} - {1'b0, t[7:0]};
      end
      cpusrb_pkg::CPUSRB_OP_SHL:
      begin
        sum = {a, cin};
      end
      cpusrb_pkg::CPUSRB_OP_SHR:
      begin
        if (wide)
          sum = {1'b0, cin, a[15:1]};
        else
          sum = {1'b0, a[15:8], cin, a[7:1]};
      end
      cpusrb_pkg::CPUSRB_OP_AND:
      begin
        sum = {1'b0, a & t};
      end
      default:
      begin
        sum = {1'b0, a | t};
      end
    endcase
    if (!wide)
    begin
      sum[15:8] = 8'h00;
    end
    out.res = sum[15:0];
    msb  = wide ? sum[15] : sum[7];
    amsb = wide ? a[15] : a[7];
    tmsb = wide ? t[15] : t[7];
    // Half carry from bit 3 into bit 4. [RL7]
    out.h = nib[4];
    // Sign of result. [RL10]
    out.n = msb;
    // Zero result on the used width. [RL11]
    out.z = wide ? (sum[15:0] == 16'h0000) : (sum[7:0] == 8'h00);
    // Two's-complement overflow. [RL12]
    if (op == cpusrb_pkg::CPUSRB_OP_ADD)
      out.v = (amsb == tmsb) && (msb != amsb);
    else if (op == cpusrb_pkg::CPUSRB_OP_SUB)
      out.v = (amsb != tmsb) && (msb != amsb);
    else
      out.v = 1'b0;
    // Carry out of bit 7 (bit 15 when wide), or the shifted-out bit. [RL13]
    if (op == cpusrb_pkg::CPUSRB_OP_SHL)
      out.c = wide ? a[15] : a[7];
    else if (op == cpusrb_pkg::CPUSRB_OP_SHR)
      out.c = a[0];
    else if (op == cpusrb_pkg::CPUSRB_OP_ADD
             || op == cpusrb_pkg::CPUSRB_OP_SUB)
      out.c = wide ? sum[16] : lo[8];
    else
      out.c = 1'b0;
  end

endmodule

// ==== tb/cpusrb_props.sv ====
// ------------------------------------------------------------
// Port checker for the status and register bank block
// ------------------------------------------------------------
module cpusrb_props
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [1:0]  irq_req_level,
  input wire logic        irq_req_valid,
  input wire logic        irq_take,
  input wire logic [15:0] bank_base_addr
);
  // Edges since reset release; saturates so it never wraps.
  logic [1:0] rst_cnt_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_cnt_r <= 2'h0;
    else if (rst_cnt_r != 2'h3)
      rst_cnt_r <= rst_cnt_r + 2'h1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_irq_quiet_rst:
    assert property (rst_cnt_r < 2'h2 |-> !irq_take)
    else $error("irq_take high right after reset");
  a_irq_needs_req:
    assert property (!irq_req_valid |=> !irq_take)
    else $error("irq_take without a pending request");
  a_irq_lvl_low:
    assert property (irq_req_valid && irq_req_level == 2'h3 |=> !irq_take)
    else $error("lowest level request was taken");
  a_bank_align:
    assert property (bank_base_addr[2:0] == 3'h0 &&
                     bank_base_addr[15:8] == 8'h01)
    else $error("bank base outside the bank area");
  a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read address taken without answer");
  a_rd_block:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted while answer pending");
  a_wr_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                     s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write taken without response");
  a_err_zero:
    assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
                     s_axi_rdata == 32'h0)
    else $error("error read returned nonzero data");
  a_rd_single:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");

  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_irq_taken: cover property ($rose(irq_take));
  c_wr_done: cover property (s_axi_bvalid);
endmodule

bind cpusrb_core cpusrb_props u_cpusrb_props (.*);

// ==== tb/tb_cpu_status_and_register_banks.sv ====
module tb_cpu_status_and_register_banks;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, arst_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, irq_req_level, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq_req_valid, irq_take;
  logic [15:0] bank_base_addr, fetch_phys_addr;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  // Case: {wide,op}, acc, tmp, result, flags, flag mask.
  logic [67:0] alu_tab [13] = '{
    68'h0_ab0f_0001_ab10_b0_ff, 68'h0_00ff_0001_0000_b5_ff,
    68'h0_007f_0001_0080_ba_ff, 68'h1_0010_0001_000f_b0_ff,
    68'h1_0000_0001_00ff_b9_ff, 68'h2_0081_0000_0002_31_71,
    68'h3_0001_0000_0000_31_71, 68'h8_00ff_0001_0100_b0_ff,
    68'h8_ffff_0001_0000_b5_ff, 68'h4_00f0_000f_0000_34_74,
    68'h5_0080_0001_0081_38_7c, 68'ha_8001_0000_0002_31_71,
    68'hb_8001_0000_4000_31_71};
  // Case: cfg, written value, expected mapped address.
  logic [47:0] bank_tab [3] = '{48'h0400_0a30_0118, 48'h0000_1f30_01f8,
                                48'h0000_0530_0128};
  logic [47:0] pc_tab [3] = '{48'h0001_9234_1234, 48'h0001_7234_7234,
                              48'h0000_9234_9234};

  cpusrb_core u_cpusrb_core (.*);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Generous ceiling: the whole run needs a few hundred cycles.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d, failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h got %h", nm, e, g);
    end
  endtask

  // Ready lines stay high, so each answer is taken when first seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task automatic cmp_rd(input logic [7:0] a, input logic [15:0] e,
                        input string nm);
    rdr(a);
    chk(nm, e, rd[15:0]);
  endtask

  task automatic rel_reset();
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_vals();
    for (int i = 0; i < 6; i++)
      cmp_rd(8'(i * 4), 16'h0, "reg_rst");
    cmp_rd(8'h18, 16'h0030, "psw_rst");
    chk("bank_rst", 16'h0100, bank_base_addr);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 6; i++)
    begin
      wr(8'(i * 4), 32'hffff_a5c3);
      cmp_rd(8'(i * 4), 16'ha5c3, "reg16");
      chk("upper", 16'h0, rd[31:16]);
    end
    wr(8'h0c, 32'h1234, 4'h1);
    cmp_rd(8'h0c, 16'ha534, "ix_lane");
    wr(8'h10, 32'h1234, 4'h2);
    cmp_rd(8'h10, 16'h12c3, "ep_lane");
  endtask

  task automatic t_alu();
    logic [3:0]  cd;
    logic [15:0] a, t, r;
    logic [7:0]  c, m;
    for (int i = 0; i < 13; i++)
    begin
      {cd, a, t, r, c, m} = alu_tab[i];
      wr(8'h04, {16'h0, a});
      wr(8'h08, {16'h0, t});
      wr(8'h18, 32'h30, 4'h1);
      wr(8'h1c, {20'h0, cd, 8'h0});
      cmp_rd(8'h04, r, "acc");
      rdr(8'h1c);
      chk("cc", {8'h0, c & m}, {8'h0, rd[7:0] & m});
    end
  endtask

  task automatic t_irq();
    irq_req_valid <= 1'b1;
    for (int il = 0; il < 4; il++)
    begin
      wr(8'h18, 32'h40 | (il << 4), 4'h1);
      for (int lv = 0; lv < 4; lv++)
      begin
        irq_req_level <= lv[1:0];
        repeat (3) @(posedge clk);
        chk("irq_take", {15'h0, lv < il}, {15'h0, irq_take});
      end
    end
    wr(8'h18, 32'h30, 4'h1);
    irq_req_level <= 2'h0;
    repeat (3) @(posedge clk);
    chk("irq_off", 16'h0, {15'h0, irq_take});
  endtask

  task automatic t_map(input logic [7:0] ra, ro, input logic [47:0] v [3],
                       input string nm);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h2c, {16'h0, v[i][47:32]});
      wr(ra, {16'h0, v[i][31:16]});
      cmp_rd(ro, v[i][15:0], nm);
      chk(nm, v[i][15:0], ra == 8'h18 ? bank_base_addr : fetch_phys_addr);
    end
  endtask

  task automatic t_unmapped();
    wr(8'h30, 32'h1234);
    chk("bresp", 16'h2, {14'h0, rs});
    rdr(8'h30);
    chk("rresp", 16'h2, {14'h0, rs});
    chk("rdata", 16'h0, rd[15:0]);
  endtask

  // A request is left pending across reset: reset must block it.
  task automatic t_mid_reset();
    wr(8'h18, 32'h70, 4'h1);
    repeat (3) @(posedge clk);
    arst_n <= 1'b0;
    rel_reset();
    repeat (3) @(posedge clk);
    chk("irq_rst", 16'h0, {15'h0, irq_take});
    cmp_rd(8'h18, 16'h0030, "psw_rst2");
    irq_req_valid <= 1'b0;
  endtask

  initial
  begin
    arst_n = 1'b0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    irq_req_level = 2'h0;
    irq_req_valid = 1'b0;
    rel_reset();
    t_reset_vals();
    t_regs();
    t_alu();
    t_irq();
    t_map(8'h18, 8'h24, bank_tab, "bank");
    cmp_rd(8'h18, 16'h0530, "psw_split");
    t_map(8'h00, 8'h28, pc_tab, "fetch");
    t_unmapped();
    t_mid_reset();
    end_sim();
  end
endmodule
